// ==== pss_blink.sv ====
// Free-running slow blink phase generator for the output status LED
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.svh"
module pss_blink #(
   parameter pss_pkg::pss_cnt_t TICK_CYC = 32'h0098_9680
) (
   input  wire logic clk,
   input  wire logic rstn,
   output var  logic blink_even,
   output var  logic blink_two_one
);

   pss_pkg::pss_cnt_t tick_cnt;
   logic [2:0]        slot;

   // Base tick; one slot is one base blink period
   always_ff @(posedge clk) begin
      if (!rstn) begin
         tick_cnt <= 32'h0000_0000;
      end else if (pss_pkg::pss_done(tick_cnt, TICK_CYC)) begin
         tick_cnt <= 32'h0000_0000;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
   end

   // Six slots serve both the 1:1 and the 2:1 pattern without a second counter
   always_ff @(posedge clk) begin
      if (!rstn) begin
         slot <= 3'h0;
      end else if (pss_pkg::pss_done(tick_cnt, TICK_CYC)) begin
         slot <= (slot == (`PSS_BLINK_SLOTS - 3'h1)) ? 3'h0 : slot + 3'h1;
      end
   end

   // Registered phases: even is high for three slots, two_one for two of each three
   always_ff @(posedge clk) begin
      if (!rstn) begin
         blink_even    <= 1'b0;
         blink_two_one <= 1'b0;
      end else begin
         blink_even    <= (slot < 3'h3);
         blink_two_one <= (slot != 3'h2) && (slot != 3'h5);
      end
   end

endmodule : pss_blink
`default_nettype wire

// ==== pss_chk.sv ====
// Pin-level assertions for the supply status block
`timescale 1ns/1ps
`default_nettype none
module pss_chk #(
   parameter pss_pkg::pss_cnt_t OFF_CYC = 32'h0000_0064
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic input_in_range,
   input wire logic main_in_reg,
   input wire logic sb_in_reg,
   input wire logic unplug_disable,
   input wire logic ot_warning,
   input wire logic fan_minor_error,
   input wire logic main_output,
   input wire logic standby_enable,
   input wire logic current_share_pin_connect,
   input wire logic power_good_n_oe,
   input wire logic input_ok_n_oe,
   input wire logic alert_n_oe,
   input wire logic present_n_out,
   input wire logic present_n_oe
);
   pss_pkg::pss_cnt_t sb_off;
   // Standby off time; saturates so a long idle never wraps to a false short rest
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sb_off <= OFF_CYC;
      end else if (standby_enable) begin
         sb_off <= 32'h0000_0000;
      end else if (sb_off < OFF_CYC) begin
         sb_off <= sb_off + 32'h0000_0001;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // Input seen in range, then lost
   sequence s_in_lost;
      input_in_range ##1 !input_in_range;
   endsequence
   property p_unplug; unplug_disable |=> !main_output; endproperty
   a_unplug: assert property (p_unplug) else $error("main on after unplug");
   property p_share; current_share_pin_connect == main_output; endproperty
   a_share: assert property (p_share) else $error("share pin mismatch");
   property p_pg; power_good_n_oe |-> $past(main_output) && $past(standby_enable)
      && $past(main_in_reg) && $past(sb_in_reg); endproperty
   a_pg: assert property (p_pg) else $error("power good without outputs");
   // Qualifier drops on the first edge, the pin one edge later
   property p_inok; s_in_lost |=> ##1 !input_ok_n_oe; endproperty
   a_inok: assert property (p_inok) else $error("input ok held");
   property p_warn; (ot_warning || fan_minor_error) && input_in_range |=> alert_n_oe;
   endproperty
   a_warn: assert property (p_warn) else $error("warning without alert");
   property p_pres; 1'b1 |=> present_n_oe && !present_n_out; endproperty
   a_pres: assert property (p_pres) else $error("presence released");
   property p_rest; $rose(standby_enable) |-> sb_off >= OFF_CYC; endproperty
   a_rest: assert property (p_rest) else $error("standby rest too short");
   property p_unpow; !input_in_range && !standby_enable
      |=> !alert_n_oe && !power_good_n_oe && !input_ok_n_oe; endproperty
   a_unpow: assert property (p_unpow) else $error("unpowered pin sink");
endmodule : pss_chk
`default_nettype wire

// ==== pss_map.svh ====
// Timing constants and clock rate for the supply status signalling block
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

`define PSS_CLK_HZ           20000000
`define PSS_CYC_PER_MS       (`PSS_CLK_HZ / 1000)

`define PSS_T_INOK_START_MS  1800
`define PSS_T_INOK_DIP_MS    100
`define PSS_T_MAIN_HOLD_MS   12
`define PSS_T_SB_HOLD_MS     40
`define PSS_T_INOK_MAIN_MS   7
`define PSS_T_INOK_SB_MS     27
`define PSS_T_OFF_MS         1000
`define PSS_T_BLINK_MS       500

`define PSS_BLINK_SLOTS      3'h6

`endif

// ==== pss_pdu.sv ====
// Far-side model: distribution controller with pull-ups on shared pins
`timescale 1ns/1ps
`default_nettype none
module pss_pdu (
   input  wire logic req_low,
   input  wire logic withdrawn,
   input  wire logic power_good_n_out,
   input  wire logic power_good_n_oe,
   input  wire logic input_ok_n_out,
   input  wire logic input_ok_n_oe,
   input  wire logic alert_n_out,
   input  wire logic alert_n_oe,
   input  wire logic present_n_out,
   input  wire logic present_n_oe,
   output wire logic main_on_request_n,
   output wire logic unplug_disable,
   output wire logic pg_w,
   output wire logic inok_w,
   output wire logic alert_w,
   output wire logic present_w
);
   // Request line is sunk to ask for main power
   assign main_on_request_n = !req_low;
   // Kill pin strapped to signal ground until the supply is pulled
   assign unplug_disable = withdrawn;
   // Pull-ups: a line reads high unless some driver sinks it
   assign pg_w = power_good_n_oe ? power_good_n_out : 1'b1;
   assign inok_w = input_ok_n_oe ? input_ok_n_out : 1'b1;
   assign alert_w = alert_n_oe ? alert_n_out : 1'b1;
   assign present_w = present_n_oe ? present_n_out : 1'b1;
endmodule : pss_pdu
`default_nettype wire

// ==== pss_pkg.sv ====
// Types and small helpers shared by the supply status signalling block
`default_nettype none
package pss_pkg;

   typedef logic [31:0] pss_cnt_t;

   typedef enum logic [1:0] {
      PSS_OUT_OFF  = 2'b00,
      PSS_OUT_ON   = 2'b01,
      PSS_OUT_HOLD = 2'b10,
      PSS_OUT_REST = 2'b11
   } pss_out_state_t;

   // Milliseconds to clock cycles, never below one cycle
   function automatic pss_cnt_t pss_ms_to_cyc(input int unsigned ms, input int unsigned cyc_ms);
      int unsigned c;
      c = ms * cyc_ms;
      if (c == 0) begin
         c = 1;
      end
      return pss_cnt_t'(c);
   endfunction : pss_ms_to_cyc

   // True on the last cycle of a wait of lim cycles
   function automatic logic pss_done(input pss_cnt_t cnt, input pss_cnt_t lim);
      return (cnt >= (lim - 32'h0000_0001));
   endfunction : pss_done

   // Larger of two counts
   function automatic pss_cnt_t pss_max(input pss_cnt_t a, input pss_cnt_t b);
      return (a > b) ? a : b;
   endfunction : pss_max

endpackage : pss_pkg
`default_nettype wire

// ==== pss_top.sv ====
// Status pins, output sequencing and front LEDs of the supply status signalling block
// How it works
// - Power-good driven low only while all outputs are on and regulating.
// - Power-good released in standby or after a main or standby fault.
// - Input-ok driven low while the input lies in the usable range.
// - Input-ok released as soon as the input leaves its usable range.
// - Alert driven low during any warning or failure, released when healthy.
// - Input LED solid green while input in range, off otherwise.
// - Output LED by fixed priority: green normal, yellow 1:1 when request high.
// - Output LED solid yellow after any shutdown of main or standby.
// - Yellow/green 2:1 on temperature warning, 1:1 on minor fan error.
// - Presence pin driven low to show the supply is plugged in.
// - Main output cut at once when unplug-disable goes high.
// - Standby output ignores the unplug-disable input.
// - Main turns on automatically with request low and input in range.
// - Input-ok asserted at most 1800 ms after input applied at start-up.
// - Input-ok reasserted at most 100 ms after a dip ends.
// - Main and standby each stay off at least 1000 ms before restart.
// - Main held 7 ms, standby 27 ms, after input-ok released.
// - Main held at least 12 ms, standby 40 ms, after input loss.
// - Current share pin disconnected whenever the supply is off.
// - An unpowered supply releases power-good, input-ok and alert; the presence pin stays driven low.
// - Request active low enables main; its rising edge clears latched faults.
// - Alert is the OR of every shutdown and warning event.
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.svh"
module pss_top #(
   parameter pss_pkg::pss_cnt_t INOK_START_CYC =
      pss_pkg::pss_ms_to_cyc(`PSS_T_INOK_START_MS, `PSS_CYC_PER_MS),
   parameter pss_pkg::pss_cnt_t INOK_DIP_CYC   =
      pss_pkg::pss_ms_to_cyc(`PSS_T_INOK_DIP_MS, `PSS_CYC_PER_MS),
   parameter pss_pkg::pss_cnt_t MAIN_HOLD_CYC  = pss_pkg::pss_max(
      pss_pkg::pss_ms_to_cyc(`PSS_T_MAIN_HOLD_MS, `PSS_CYC_PER_MS),
      pss_pkg::pss_ms_to_cyc(`PSS_T_INOK_MAIN_MS, `PSS_CYC_PER_MS)),
   parameter pss_pkg::pss_cnt_t SB_HOLD_CYC    = pss_pkg::pss_max(
      pss_pkg::pss_ms_to_cyc(`PSS_T_SB_HOLD_MS, `PSS_CYC_PER_MS),
      pss_pkg::pss_ms_to_cyc(`PSS_T_INOK_SB_MS, `PSS_CYC_PER_MS)),
   parameter pss_pkg::pss_cnt_t OFF_CYC        =
      pss_pkg::pss_ms_to_cyc(`PSS_T_OFF_MS, `PSS_CYC_PER_MS),
   parameter pss_pkg::pss_cnt_t BLINK_CYC      =
      pss_pkg::pss_ms_to_cyc(`PSS_T_BLINK_MS, `PSS_CYC_PER_MS)
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic input_in_range,
   input  wire logic main_in_reg,
   input  wire logic sb_in_reg,
   input  wire logic main_on_request_n,
   input  wire logic unplug_disable,
   input  wire logic ot_shutdown,
   input  wire logic main_ov,
   input  wire logic main_uv,
   input  wire logic main_oc,
   input  wire logic sb_ov,
   input  wire logic sb_uv,
   input  wire logic sb_oc,
   input  wire logic ot_warning,
   input  wire logic fan_minor_error,
   output var  logic main_output,
   output var  logic standby_enable,
   output var  logic current_share_pin_connect,
   output var  logic power_good_n_out,
   output var  logic power_good_n_oe,
   output var  logic input_ok_n_out,
   output var  logic input_ok_n_oe,
   output var  logic alert_n_out,
   output var  logic alert_n_oe,
   output var  logic present_n_out,
   output var  logic present_n_oe,
   output var  logic led_in_green,
   output var  logic led_out_green,
   output var  logic led_out_yellow
);

   pss_pkg::pss_out_state_t m_state;
   pss_pkg::pss_out_state_t next_m_state;
   pss_pkg::pss_out_state_t s_state;
   pss_pkg::pss_out_state_t next_s_state;
   pss_pkg::pss_cnt_t       m_cnt;
   pss_pkg::pss_cnt_t       s_cnt;
   pss_pkg::pss_cnt_t       q_cnt;
   logic                    input_ok;
   logic                    req_q;
   logic                    req_rise;
   logic                    main_fault;
   logic                    sb_fault;
   logic                    main_set;
   logic                    sb_set;
   logic                    fault_clr;
   logic                    cold;
   logic                    powered;
   logic                    good;
   logic                    blink_even;
   logic                    blink_two_one;

   // Slow blink phases for the output LED
   pss_blink #(
      .TICK_CYC      (BLINK_CYC)
   ) u_blink (
      .clk           (clk),
      .rstn          (rstn),
      .blink_even    (blink_even),
      .blink_two_one (blink_two_one)
   );

   // Fault events and the clears that act on the latched faults
   assign main_set  = ot_shutdown | main_ov | main_uv | main_oc;
   assign sb_set    = sb_ov | sb_uv | sb_oc;
   assign req_rise  = main_on_request_n & ~req_q;
   assign fault_clr = req_rise | (~input_in_range & (s_state == pss_pkg::PSS_OUT_OFF));
   // Standby fully down means the next input-ok is a start-up, not a dip
   assign cold      = (s_state == pss_pkg::PSS_OUT_OFF) || (s_state == pss_pkg::PSS_OUT_REST);
   // No input and no standby: the unit must not load the shared pins
   assign powered   = input_in_range | standby_enable;

   // Request edge detector
   always_ff @(posedge clk) begin
      if (!rstn) begin
         req_q <= 1'b1;
      end else begin
         req_q <= main_on_request_n;
      end
   end

   // Latched shutdowns; a new event in the clearing cycle wins over the clear
   always_ff @(posedge clk) begin
      if (!rstn) begin
         main_fault <= 1'b0;
         sb_fault   <= 1'b0;
      end else begin
         main_fault <= main_set | (main_fault & ~fault_clr);
         sb_fault   <= sb_set | (sb_fault & ~fault_clr);
      end
   end

   // Input qualification: drop at once, reassert after start-up or dip delay
   always_ff @(posedge clk) begin
      if (!rstn) begin
         input_ok <= 1'b0;
         q_cnt    <= 32'h0000_0000;
      end else if (!input_in_range) begin
         input_ok <= 1'b0;
         q_cnt    <= 32'h0000_0000;
      end else if (!input_ok) begin
         if (pss_pkg::pss_done(q_cnt, cold ? INOK_START_CYC : INOK_DIP_CYC)) begin
            input_ok <= 1'b1;
            q_cnt    <= 32'h0000_0000;
         end else begin
            q_cnt <= q_cnt + 32'h0000_0001;
         end
      end
   end

   // Standby sequencing; unplug-disable deliberately plays no part here
   always_comb begin
      next_s_state = s_state;
      unique case (s_state)
         pss_pkg::PSS_OUT_OFF: begin
            if (input_ok && !sb_fault) begin
               next_s_state = pss_pkg::PSS_OUT_ON;
            end
         end
         pss_pkg::PSS_OUT_ON: begin
            if (sb_fault) begin
               next_s_state = pss_pkg::PSS_OUT_REST;
            end else if (!input_in_range) begin
               next_s_state = pss_pkg::PSS_OUT_HOLD;
            end
         end
         pss_pkg::PSS_OUT_HOLD: begin
            if (sb_fault) begin
               next_s_state = pss_pkg::PSS_OUT_REST;
            end else if (input_in_range) begin
               next_s_state = pss_pkg::PSS_OUT_ON;
            end else if (pss_pkg::pss_done(s_cnt, SB_HOLD_CYC)) begin
               next_s_state = pss_pkg::PSS_OUT_REST;
            end
         end
         pss_pkg::PSS_OUT_REST: begin
            if (pss_pkg::pss_done(s_cnt, OFF_CYC)) begin
               next_s_state = pss_pkg::PSS_OUT_OFF;
            end
         end
      endcase
   end

   // Main sequencing; a standby fault also takes the main output down
   always_comb begin
      next_m_state = m_state;
      unique case (m_state)
         pss_pkg::PSS_OUT_OFF: begin
            if (input_ok && !main_on_request_n && !unplug_disable && !main_fault
                && !sb_fault && (s_state == pss_pkg::PSS_OUT_ON)) begin
               next_m_state = pss_pkg::PSS_OUT_ON;
            end
         end
         pss_pkg::PSS_OUT_ON: begin
            if (unplug_disable || main_on_request_n || main_fault || sb_fault) begin
               next_m_state = pss_pkg::PSS_OUT_REST;
            end else if (!input_in_range) begin
               next_m_state = pss_pkg::PSS_OUT_HOLD;
            end
         end
         pss_pkg::PSS_OUT_HOLD: begin
            if (unplug_disable || main_on_request_n || main_fault || sb_fault) begin
               next_m_state = pss_pkg::PSS_OUT_REST;
            end else if (input_in_range) begin
               next_m_state = pss_pkg::PSS_OUT_ON;
            end else if (pss_pkg::pss_done(m_cnt, MAIN_HOLD_CYC)) begin
               next_m_state = pss_pkg::PSS_OUT_REST;
            end
         end
         pss_pkg::PSS_OUT_REST: begin
            if (pss_pkg::pss_done(m_cnt, OFF_CYC)) begin
               next_m_state = pss_pkg::PSS_OUT_OFF;
            end
         end
      endcase
   end

   // State registers; each timer restarts on every state change
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_state <= pss_pkg::PSS_OUT_OFF;
         s_cnt   <= 32'h0000_0000;
      end else begin
         s_state <= next_s_state;
         s_cnt   <= (next_s_state != s_state) ? 32'h0000_0000 : s_cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         m_state <= pss_pkg::PSS_OUT_OFF;
         m_cnt   <= 32'h0000_0000;
      end else begin
         m_state <= next_m_state;
         m_cnt   <= (next_m_state != m_state) ? 32'h0000_0000 : m_cnt + 32'h0000_0001;
      end
   end

   // Output enables follow the next state so unplug acts on the very next edge
   always_ff @(posedge clk) begin
      if (!rstn) begin
         main_output               <= 1'b0;
         standby_enable            <= 1'b0;
         current_share_pin_connect <= 1'b0;
      end else begin
         main_output    <= (next_m_state == pss_pkg::PSS_OUT_ON)
                           || (next_m_state == pss_pkg::PSS_OUT_HOLD);
         standby_enable <= (next_s_state == pss_pkg::PSS_OUT_ON)
                           || (next_s_state == pss_pkg::PSS_OUT_HOLD);
         current_share_pin_connect <= (next_m_state == pss_pkg::PSS_OUT_ON)
                                      || (next_m_state == pss_pkg::PSS_OUT_HOLD);
      end
   end

   // Everything on, regulating and fault free
   assign good = main_output & standby_enable & main_in_reg & sb_in_reg
                 & ~main_fault & ~sb_fault & ~main_on_request_n;

   // Open-drain pins only ever pull low; the enable carries the level
   always_ff @(posedge clk) begin
      if (!rstn) begin
         power_good_n_out <= 1'b0;
         input_ok_n_out   <= 1'b0;
         alert_n_out      <= 1'b0;
         present_n_out    <= 1'b0;
         power_good_n_oe  <= 1'b0;
         input_ok_n_oe    <= 1'b0;
         alert_n_oe       <= 1'b0;
         present_n_oe     <= 1'b0;
      end else begin
         power_good_n_out <= 1'b0;
         input_ok_n_out   <= 1'b0;
         alert_n_out      <= 1'b0;
         present_n_out    <= 1'b0;
         power_good_n_oe  <= good & powered;
         input_ok_n_oe    <= input_ok & powered;
         alert_n_oe       <= (main_fault | sb_fault | ot_warning | fan_minor_error)
                             & powered;
         present_n_oe     <= 1'b1;
      end
   end

   // Input LED mirrors the raw in-range level, not the delayed input-ok
   always_ff @(posedge clk) begin
      if (!rstn) begin
         led_in_green <= 1'b0;
      end else begin
         led_in_green <= input_in_range;
      end
   end

   // Output LED, tested top down; a warning spoils normal operation
   always_ff @(posedge clk) begin
      if (!rstn) begin
         led_out_green  <= 1'b0;
         led_out_yellow <= 1'b0;
      end else if (good && !ot_warning && !fan_minor_error) begin
         led_out_green  <= 1'b1;
         led_out_yellow <= 1'b0;
      end else if (main_on_request_n && standby_enable) begin
         led_out_green  <= 1'b0;
         led_out_yellow <= blink_even;
      end else if (main_fault || sb_fault || (main_output && !main_in_reg)
                   || (standby_enable && !sb_in_reg)) begin
         led_out_green  <= 1'b0;
         led_out_yellow <= 1'b1;
      end else if (ot_warning) begin
         led_out_green  <= ~blink_two_one;
         led_out_yellow <= blink_two_one;
      end else if (fan_minor_error) begin
         led_out_green  <= ~blink_even;
         led_out_yellow <= blink_even;
      end else begin
         led_out_green  <= 1'b0;
         led_out_yellow <= 1'b0;
      end
   end

endmodule : pss_top
`default_nettype wire

// ==== tb_top.sv ====
// Directed bench for the supply status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
`define WAITF(c, l) begin n = 0; \
   while (((c) !== 1'b1) && (n < (l))) begin tick(1); n++; end \
   if ((c) !== 1'b1) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, n, (l)); end end
module tb_top;
   localparam pss_pkg::pss_cnt_t T_INOK = 32'h0000_0028;
   localparam pss_pkg::pss_cnt_t T_DIP = 32'h0000_000A;
   localparam pss_pkg::pss_cnt_t T_MH = 32'h0000_000C;
   localparam pss_pkg::pss_cnt_t T_SH = 32'h0000_0028;
   localparam pss_pkg::pss_cnt_t T_OFF = 32'h0000_0064;
   localparam pss_pkg::pss_cnt_t T_BL = 32'h0000_0004;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic input_in_range = 1'b0;
   logic main_in_reg = 1'b1;
   logic sb_in_reg = 1'b1;
   logic req_low = 1'b1;
   logic withdrawn = 1'b0;
   logic ot_warning = 1'b0;
   logic fan_minor_error = 1'b0;
   logic [6:0] flt = 7'h00;
   pss_pkg::pss_cnt_t off_run = 32'h0000_0000;
   int n_mismatch = 0;
   int n_tests = 0;
   int n;
   int m;
   wire main_on_request_n, unplug_disable, main_output, standby_enable;
   wire current_share_pin_connect, power_good_n_out, power_good_n_oe, input_ok_n_out;
   wire input_ok_n_oe, alert_n_out, alert_n_oe, present_n_out, present_n_oe;
   wire led_in_green, led_out_green, led_out_yellow, pg_w, inok_w, alert_w, present_w;
   pss_top #(.INOK_START_CYC(T_INOK), .INOK_DIP_CYC(T_DIP), .MAIN_HOLD_CYC(T_MH),
      .SB_HOLD_CYC(T_SH), .OFF_CYC(T_OFF), .BLINK_CYC(T_BL)) dut_u (.clk, .rstn,
      .input_in_range, .main_in_reg, .sb_in_reg, .main_on_request_n, .unplug_disable,
      .ot_shutdown(flt[0]), .main_ov(flt[1]), .main_uv(flt[2]), .main_oc(flt[3]),
      .sb_ov(flt[4]), .sb_uv(flt[5]), .sb_oc(flt[6]), .ot_warning, .fan_minor_error,
      .main_output, .standby_enable, .current_share_pin_connect, .power_good_n_out,
      .power_good_n_oe, .input_ok_n_out, .input_ok_n_oe, .alert_n_out, .alert_n_oe,
      .present_n_out, .present_n_oe, .led_in_green, .led_out_green, .led_out_yellow);
   pss_pdu pdu_u (.req_low, .withdrawn, .power_good_n_out, .power_good_n_oe,
      .input_ok_n_out, .input_ok_n_oe, .alert_n_out, .alert_n_oe, .present_n_out,
      .present_n_oe, .main_on_request_n, .unplug_disable, .pg_w, .inok_w, .alert_w,
      .present_w);
   // 20 MHz clock
   always #25 clk = ~clk;
   // Length of the latest main-off stretch, read when main comes back
   always @(posedge clk) begin
      if (main_output === 1'b1) begin
         off_run <= 32'h0000_0000;
      end else begin
         off_run <= off_run + 32'h0000_0001;
      end
   end
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop
   // Step whole clocks, then settle just past the edge
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   // Count LED colours over one full six-slot blink cycle
   task automatic blink(input int ey, input int eg);
      int y;
      int g;
      y = 0;
      g = 0;
      tick(3);
      repeat (6 * T_BL) begin
         tick(1);
         y += int'(led_out_yellow);
         g += int'(led_out_green);
      end
      `CHK(y, ey)
      `CHK(g, eg)
   endtask : blink
   // Hang guard, about nine times the expected run
   initial begin
      #500000;
      n_mismatch++;
      report_and_stop();
   end
   // Start-up, warnings, shutdowns, unplug, dip and long loss
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      tick(1);
      `CHK({present_w, inok_w, pg_w}, 3'h3)
      input_in_range <= 1'b1;
      `WAITF(inok_w === 1'b0, 60)
      `CHK(n <= T_INOK + 3, 1'b1)
      `WAITF(main_output, 10)
      `CHK({standby_enable, current_share_pin_connect}, 2'h3)
      tick(3);
      `CHK({pg_w, alert_w, led_in_green, led_out_green, led_out_yellow}, 5'h0E)
      // Main out of regulation: power good let go, output LED solid yellow
      main_in_reg <= 1'b0;
      tick(2);
      `CHK({pg_w, led_out_green, led_out_yellow}, 3'h5)
      main_in_reg <= 1'b1;
      tick(2);
      ot_warning <= 1'b1;
      tick(2);
      `CHK(alert_w, 1'b0)
      blink(16, 8);
      ot_warning <= 1'b0;
      fan_minor_error <= 1'b1;
      blink(12, 12);
      fan_minor_error <= 1'b0;
      req_low <= 1'b0;
      blink(12, 0);
      `CHK({main_output, current_share_pin_connect}, 2'h0)
      req_low <= 1'b1;
      `WAITF(main_output, 300)
      `CHK(off_run >= T_OFF, 1'b1)
      // Each shutdown kind in turn, cleared by a request toggle
      for (int i = 0; i < 7; i++) begin
         flt[i] <= 1'b1;
         tick(1);
         flt[i] <= 1'b0;
         tick(4);
         `CHK({led_out_yellow, led_out_green, main_output}, 3'h4)
         `CHK({alert_w, pg_w}, 2'h1)
         req_low <= 1'b0;
         tick(2);
         req_low <= 1'b1;
         `WAITF(main_output, 800)
         `CHK(off_run >= T_OFF, 1'b1)
         tick(3);
         `CHK(pg_w, 1'b0)
      end
      withdrawn <= 1'b1;
      tick(1);
      `CHK({main_output, standby_enable}, 2'h1)
      withdrawn <= 1'b0;
      `WAITF(main_output, 800)
      `CHK(main_output, 1'b1)
      input_in_range <= 1'b0;
      tick(2);
      `CHK({inok_w, led_in_green}, 2'h2)
      tick(3);
      `CHK({main_output, standby_enable}, 2'h3)
      input_in_range <= 1'b1;
      `WAITF(inok_w === 1'b0, 40)
      `CHK(n <= T_DIP + 3, 1'b1)
      input_in_range <= 1'b0;
      `WAITF(main_output === 1'b0, 100)
      `CHK(n >= T_MH, 1'b1)
      m = n;
      `WAITF(standby_enable === 1'b0, 100)
      `CHK(m + n >= T_SH, 1'b1)
      // A warning on an unpowered unit must still leave the shared alert line alone
      ot_warning <= 1'b1;
      tick(3);
      `CHK({pg_w, inok_w, alert_w, present_w}, 4'hE)
      report_and_stop();
   end
endmodule : tb_top
bind pss_top pss_chk #(.OFF_CYC(OFF_CYC)) chk_u (.clk, .rstn, .input_in_range,
   .main_in_reg, .sb_in_reg, .unplug_disable, .ot_warning, .fan_minor_error,
   .main_output, .standby_enable, .current_share_pin_connect, .power_good_n_oe,
   .input_ok_n_oe, .alert_n_oe, .present_n_out, .present_n_oe);
`default_nettype wire
